// >>> logic/adws_consts.svh
// Address map bounds, configuration bit positions and reset vector
// Included by the strobe and decoder files; no logic here
`ifndef ADWS_CONSTS_SVH
`define ADWS_CONSTS_SVH
`define ADWS_RESET_VECTOR   24'hff2080
`define ADWS_CPU_SFR_LO     24'h000000
`define ADWS_CPU_SFR_HI     24'h000019
`define ADWS_LOW_RF_LO      24'h00001a
`define ADWS_LOW_RF_HI      24'h0000ff
`define ADWS_UP_RF_LO       24'h000100
`define ADWS_UP_RF_HI       24'h0003ff
`define ADWS_RAM_LO         24'h000400
`define ADWS_RAM_HI         24'h000fff
`define ADWS_EXT_A_LO       24'h001000
`define ADWS_EXT_A_HI       24'h001bff
`define ADWS_PSFR_LO        24'h001c00
`define ADWS_PSFR_HI        24'h001fdf
`define ADWS_MSFR_LO        24'h001fe0
`define ADWS_MSFR_HI        24'h001fff
`define ADWS_EXT_B_LO       24'h002000
`define ADWS_EXT_B_HI       24'h0023ff
`define ADWS_ROMCP_LO       24'h002400
`define ADWS_ROMCP_HI       24'h003fff
`define ADWS_EXT_C_LO       24'h004000
`define ADWS_EXT_C_HI       24'h1effff
`define ADWS_OVL_LO         24'h1f0000
`define ADWS_OVL_HI         24'hfeffff
`define ADWS_ICE_LO         24'hff0000
`define ADWS_ICE_HI         24'hff03ff
`define ADWS_MRAM_LO        24'hff0400
`define ADWS_MRAM_HI        24'hff0fff
`define ADWS_EXT_D_LO       24'hff1000
`define ADWS_EXT_D_HI       24'hff1fff
`define ADWS_SPM_LO         24'hff2000
`define ADWS_SPM_HI         24'hff207f
`define ADWS_PIH_LO         24'hff20c0
`define ADWS_PIH_HI         24'hff213f
`define ADWS_PROG_LO        24'hff2000
`define ADWS_PROG_HI        24'hff3fff
`define ADWS_EXT_E_LO       24'hff4000
`define ADWS_EXT_E_HI       24'hffffff
`define ADWS_ROM_OFS_MASK   24'h001fff
`define ADWS_CHIP_CONFIG_REG_0_WR_BIT    2
`define ADWS_CONFIG_BYTE_1_ROM_BIT   2
`endif

// >>> logic/adws_pkg.sv
// Types shared by the decoder and the strobe generator
// Assumes adws_consts.svh is on the include path
package adws_pkg;
   typedef enum logic [3:0] {
      ADWS_T_NONE     = 4'h0,
      ADWS_T_CPU_SFR  = 4'h1,
      ADWS_T_LOW_RF   = 4'h2,
      ADWS_T_UP_RF    = 4'h3,
      ADWS_T_RAM      = 4'h4,
      ADWS_T_PSFR     = 4'h5,
      ADWS_T_MSFR     = 4'h6,
      ADWS_T_ROM      = 4'h7,
      ADWS_T_EXT      = 4'h8,
      ADWS_T_ICE      = 4'h9,
      ADWS_T_RESERVED = 4'ha
   } adws_target_t;

   typedef enum logic [1:0] {
      ADWS_M_DIRECT   = 2'h0,
      ADWS_M_WINDOWED = 2'h1,
      ADWS_M_OTHER    = 2'h2
   } adws_mode_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [23:0] addr;
      logic        byte_lo;
      logic        byte_hi;
      adws_mode_t  mode;
      logic        fetch;
   } adws_req_t;

   typedef struct packed {
      adws_target_t target;
      logic         vector_area;
      logic         pih_area;
      logic         mode_fault;
      logic [23:0]  local_addr;
   } adws_sel_t;

   typedef enum logic [1:0] {
      ADWS_S_RESET = 2'h0,
      ADWS_S_BOOT  = 2'h1,
      ADWS_S_RUN   = 2'h2
   } adws_state_t;
endpackage

// >>> logic/adws_strobe.sv
// External write strobe generator for the shared pins
// Assumes a combinational external-write request from the decoder top
`timescale 1ns/100ps
`include "adws_consts.svh"
module adws_strobe
   import adws_pkg::*;
(
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   input  wire logic ext_write_i,
   input  wire logic bus16_i,
   input  wire logic byte_lo_i,
   input  wire logic byte_hi_i,
   input  wire logic ext_cycle_i,
   input  wire logic combined_sel_i,
   output logic      low_byte_write_strobe_n_o,
   output logic      high_byte_write_strobe_n_o
);
   wire lo_want;
   wire hi_want;
   wire combined_wr;
   wire bhe;
   wire next_pin_lo_n;
   wire next_pin_hi_n;

   // R6 - low byte or word
   // R7 - every 8-bit write
   assign lo_want = ext_write_i & (bus16_i ? byte_lo_i : 1'b1);
   // R4 - high byte or word
   // R5 - every 8-bit write
   assign hi_want = ext_write_i & (bus16_i ? byte_hi_i : 1'b1);
   // R1 - external writes only
   assign combined_wr = ext_write_i;
   // Byte high enable follows any 16-bit-bus external cycle touching the high lane
   assign bhe = ext_cycle_i & bus16_i & byte_hi_i;
   // R2 - pin one select
   assign next_pin_lo_n = combined_sel_i ? ~combined_wr : ~lo_want;
   // R3 - pin two select
   assign next_pin_hi_n = combined_sel_i ? ~bhe : ~hi_want;

   // Registered so the pins never glitch on decode settling
   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_byte_write_strobe_n_o  <= 1'b1;
         high_byte_write_strobe_n_o <= 1'b1;
      end else begin
         low_byte_write_strobe_n_o  <= next_pin_lo_n;
         high_byte_write_strobe_n_o <= next_pin_hi_n;
      end
   end
endmodule

// >>> logic/adws_decoder.sv
// Address decoder for a 24-bit linear space with external strobes
// Assumes requests synchronous to clk_sys_i, one per cycle
`timescale 1ns/100ps
`include "adws_consts.svh"

// Function
// R1 - Write strobe only for external writes
// R2 - Config bit picks combined or low strobe
// R3 - Config bit picks byte enable or high
// R4 - 16-bit: high strobe for high/word writes
// R5 - 8-bit: high strobe on every write
// R6 - 16-bit: low strobe for low/word writes
// R7 - 8-bit: low strobe on every write
// R8 - First fetch after reset at FF2080
// R9 - Program page internal or external by pin
// R10 - ROM copy low or external by config
// R11 - Code RAM mirrored in top page
// R12 - Listed ranges go to external bus
// R13 - Memory and peripheral special registers mapped
// R14 - CPU registers and register files mapped
// R15 - Emulator and overlaid space reserved
// R16 - Vector areas lie in program memory
// R17 - Direct and windowed modes restricted
// R18 - Software writes reserved areas conventionally
// R19 - Exactly one target per address
module adws_decoder
   import adws_pkg::*;
(
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   input  wire adws_req_t   req_i,
   input  wire logic [7:0]  chip_config_reg_0_i,
   input  wire logic [7:0]  config_byte_1_i,
   input  wire logic        external_access_select_n_i,
   input  wire logic        bus16_i,
   output adws_sel_t        sel_o,
   output logic             sel_valid_o,
   output logic             ext_cycle_o,
   output logic [23:0]      ext_addr_o,
   output logic             boot_fetch_o,
   output logic [23:0]      boot_addr_o,
   output logic             low_byte_write_strobe_n_o,
   output logic             high_byte_write_strobe_n_o
);
   logic        rst_meta;
   logic        rst_sync;
   adws_state_t state;
   adws_state_t next_state;
   adws_sel_t   next_sel;
   logic        ext_write;
   logic        ext_hi;
   logic        ext_lo;
   logic        ext_w16;

   wire [23:0] a;
   wire in_cpu_sfr;
   wire in_low_rf;
   wire in_up_rf;
   wire in_ram;
   wire in_mram;
   wire in_psfr;
   wire in_msfr;
   wire in_romcp;
   wire in_prog;
   wire in_ext;
   wire in_ice;
   wire in_ovl;
   wire ea_internal;
   wire copy_ext;
   wire combined_sel;
   wire [23:0] rom_local;
   wire [23:0] ram_local;
   adws_target_t tgt;
   wire mode_bad;
   wire take;

   // Two-flop reset release
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   assign a = req_i.addr;

   // R14 - register space ranges
   assign in_cpu_sfr = (a <= `ADWS_CPU_SFR_HI);
   assign in_low_rf  = (a >= `ADWS_LOW_RF_LO) && (a <= `ADWS_LOW_RF_HI);
   assign in_up_rf   = (a >= `ADWS_UP_RF_LO) && (a <= `ADWS_UP_RF_HI);
   // R11 - both RAM windows
   assign in_ram     = (a >= `ADWS_RAM_LO) && (a <= `ADWS_RAM_HI);
   assign in_mram    = (a >= `ADWS_MRAM_LO) && (a <= `ADWS_MRAM_HI);
   // R13 - special register ranges; R10/R9 ROM copy and program ranges
   assign in_psfr    = (a >= `ADWS_PSFR_LO) && (a <= `ADWS_PSFR_HI);
   assign in_msfr    = (a >= `ADWS_MSFR_LO) && (a <= `ADWS_MSFR_HI);
   assign in_romcp   = (a >= `ADWS_ROMCP_LO) && (a <= `ADWS_ROMCP_HI);
   assign in_prog    = (a >= `ADWS_PROG_LO) && (a <= `ADWS_PROG_HI);
   // R12 - external bus ranges
   assign in_ext     = ((a >= `ADWS_EXT_A_LO) && (a <= `ADWS_EXT_A_HI))
                    || ((a >= `ADWS_EXT_B_LO) && (a <= `ADWS_EXT_B_HI))
                    || ((a >= `ADWS_EXT_C_LO) && (a <= `ADWS_EXT_C_HI))
                    || ((a >= `ADWS_EXT_D_LO) && (a <= `ADWS_EXT_D_HI))
                    || (a >= `ADWS_EXT_E_LO);
   // R15 - reserved spaces
   assign in_ice     = (a >= `ADWS_ICE_LO) && (a <= `ADWS_ICE_HI);
   assign in_ovl     = (a >= `ADWS_OVL_LO) && (a <= `ADWS_OVL_HI);

   // R9 - pin high means internal
   assign ea_internal = external_access_select_n_i;
   // R10 - copy goes external when set
   assign copy_ext    = config_byte_1_i[`ADWS_CONFIG_BYTE_1_ROM_BIT];
   assign combined_sel = chip_config_reg_0_i[`ADWS_CHIP_CONFIG_REG_0_WR_BIT];
   assign rom_local   = a & `ADWS_ROM_OFS_MASK;
   assign ram_local   = {12'h000, a[11:0]};

   // R19 - priority chain, ranges disjoint
   assign tgt = in_cpu_sfr ? ADWS_T_CPU_SFR :
                in_low_rf  ? ADWS_T_LOW_RF  :
                in_up_rf   ? ADWS_T_UP_RF   :
                (in_ram || in_mram) ? ADWS_T_RAM :
                in_psfr    ? ADWS_T_PSFR    :
                in_msfr    ? ADWS_T_MSFR    :
                in_romcp   ? (copy_ext ? ADWS_T_EXT : ADWS_T_ROM) :
                in_prog    ? (ea_internal ? ADWS_T_ROM : ADWS_T_EXT) :
                in_ext     ? ADWS_T_EXT     :
                in_ice     ? ADWS_T_ICE     :
                in_ovl     ? ADWS_T_RESERVED : ADWS_T_NONE;

   // R17 - addressing mode checks
   assign mode_bad = (req_i.mode == ADWS_M_DIRECT && !in_low_rf && !in_cpu_sfr)
                  || (req_i.mode == ADWS_M_WINDOWED && !in_up_rf && !in_psfr);

   // Taken only when running, mode legal
   assign take = req_i.valid && (state == ADWS_S_RUN) && !mode_bad;

   always_comb begin
      next_sel.target      = tgt;
      // R16 - vector areas in program space
      next_sel.vector_area = (a >= `ADWS_SPM_LO) && (a <= `ADWS_SPM_HI);
      next_sel.pih_area    = (a >= `ADWS_PIH_LO) && (a <= `ADWS_PIH_HI);
      next_sel.mode_fault  = req_i.valid && mode_bad;
      if (tgt == ADWS_T_ROM) begin
         next_sel.local_addr = rom_local;
      end else if (tgt == ADWS_T_RAM) begin
         next_sel.local_addr = ram_local;
      end else begin
         next_sel.local_addr = a;
      end
   end

   always_comb begin
      case (state)
         ADWS_S_RESET: next_state = ADWS_S_BOOT;
         ADWS_S_BOOT:  next_state = ADWS_S_RUN;
         ADWS_S_RUN:   next_state = ADWS_S_RUN;
         default:      next_state = ADWS_S_RESET;
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge rst_sync) begin
      if (!rst_sync) begin
         state <= ADWS_S_RESET;
      end else begin
         state <= next_state;
      end
   end

   // R8 - reset vector fetch pulse
   always_ff @(posedge clk_sys_i or negedge rst_sync) begin
      if (!rst_sync) begin
         boot_fetch_o <= 1'b0;
         boot_addr_o  <= 24'h000000;
      end else begin
         boot_fetch_o <= (state == ADWS_S_BOOT);
         boot_addr_o  <= `ADWS_RESET_VECTOR;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_sync) begin
      if (!rst_sync) begin
         sel_o       <= '0;
         sel_valid_o <= 1'b0;
         ext_cycle_o <= 1'b0;
         ext_addr_o  <= 24'h000000;
      end else begin
         sel_o       <= next_sel;
         sel_valid_o <= take;
         ext_cycle_o <= take && (tgt == ADWS_T_EXT);
         ext_addr_o  <= a;
      end
   end

   // R1 - external write qualifies strobes
   assign ext_write = take && req_i.write && (tgt == ADWS_T_EXT);
   assign ext_lo    = req_i.byte_lo;
   assign ext_hi    = req_i.byte_hi;
   assign ext_w16   = bus16_i;

   adws_strobe u_strobe (
      .clk_sys_i                  (clk_sys_i),
      .rst_n_i                    (rst_sync),
      .ext_write_i                (ext_write),
      .bus16_i                    (ext_w16),
      .byte_lo_i                  (ext_lo),
      .byte_hi_i                  (ext_hi),
      .ext_cycle_i                (take && (tgt == ADWS_T_EXT)),
      .combined_sel_i             (combined_sel),
      .low_byte_write_strobe_n_o  (low_byte_write_strobe_n_o),
      .high_byte_write_strobe_n_o (high_byte_write_strobe_n_o)
   );
endmodule

// >>> verif/adws_ext_mem.sv
// External memory model on the low write strobe pin
// Assumes strobes registered on clk_sys_i, one cycle per write
`timescale 1ns/100ps
module adws_ext_mem (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   input  wire logic        low_byte_write_strobe_n_i,
   output logic [15:0]      lo_writes_o
);
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         lo_writes_o <= 16'h0000;
      end else if (!low_byte_write_strobe_n_i) begin
         lo_writes_o <= lo_writes_o + 16'h0001;
      end
   end
endmodule

// >>> verif/adws_decoder_props.sv
// Port-level assertions for the decoder and strobes
// Bound to adws_decoder; sees its ports only
`timescale 1ns/100ps
module adws_decoder_chk
   import adws_pkg::*;
(
   input wire logic        clk_sys_i,
   input wire logic        reset_n_i,
   input wire adws_req_t   req_i,
   input wire logic [7:0]  chip_config_reg_0_i,
   input wire logic        bus16_i,
   input wire adws_sel_t   sel_o,
   input wire logic        sel_valid_o,
   input wire logic        ext_cycle_o,
   input wire logic        boot_fetch_o,
   input wire logic [23:0] boot_addr_o,
   input wire logic        low_byte_write_strobe_n_o,
   input wire logic        high_byte_write_strobe_n_o
);
   logic        wr_q, cmb_q, b16_q, lo_q, hi_q;
   adws_mode_t  md_q;
   logic [23:0] ad_q;
   wire         ewr = sel_valid_o & ext_cycle_o & wr_q;
   // Inputs one cycle back, lined up with registered outputs
   always_ff @(posedge clk_sys_i) begin
      wr_q  <= req_i.write;
      cmb_q <= chip_config_reg_0_i[2];
      b16_q <= bus16_i;
      lo_q  <= req_i.byte_lo;
      hi_q  <= req_i.byte_hi;
      md_q  <= req_i.mode;
      ad_q  <= req_i.addr;
   end
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_boot_pulse;
      (boot_fetch_o && boot_addr_o == 24'hff2080) ##1 !boot_fetch_o;
   endsequence
   property p_strobe_cause;
      !low_byte_write_strobe_n_o || (!high_byte_write_strobe_n_o && !cmb_q) |-> ewr;
   endproperty
   a_strobe_cause: assert property (p_strobe_cause) else $error("strobe without ext write");
   property p_comb_wr;
      ewr && cmb_q |-> !low_byte_write_strobe_n_o;
   endproperty
   a_comb_wr: assert property (p_comb_wr) else $error("combined strobe missing");
   property p_comb_bhe;
      sel_valid_o && ext_cycle_o && cmb_q |-> high_byte_write_strobe_n_o == !(b16_q && hi_q);
   endproperty
   a_comb_bhe: assert property (p_comb_bhe) else $error("byte high enable wrong");
   property p_hi16;
      ewr && !cmb_q && b16_q |-> high_byte_write_strobe_n_o == !hi_q;
   endproperty
   a_hi16: assert property (p_hi16) else $error("high strobe wrong on 16-bit");
   property p_8bit;
      ewr && !cmb_q && !b16_q |-> !low_byte_write_strobe_n_o && !high_byte_write_strobe_n_o;
   endproperty
   a_8bit: assert property (p_8bit) else $error("strobes wrong on 8-bit");
   property p_lo16;
      ewr && !cmb_q && b16_q |-> low_byte_write_strobe_n_o == !lo_q;
   endproperty
   a_lo16: assert property (p_lo16) else $error("low strobe wrong on 16-bit");
   property p_boot;
      $rose(reset_n_i) |-> ##[1:6] s_boot_pulse;
   endproperty
   a_boot: assert property (p_boot) else $error("boot fetch missing");
   property p_mode;
      sel_valid_o |-> !sel_o.mode_fault && !(md_q == ADWS_M_DIRECT && ad_q > 24'h0000ff);
   endproperty
   a_mode: assert property (p_mode) else $error("refused mode accepted");
endmodule
bind adws_decoder adws_decoder_chk adws_decoder_chk_i (.clk_sys_i, .reset_n_i, .req_i,
   .chip_config_reg_0_i, .bus16_i, .sel_o, .sel_valid_o, .ext_cycle_o, .boot_fetch_o,
   .boot_addr_o, .low_byte_write_strobe_n_o, .high_byte_write_strobe_n_o);

// >>> verif/address_decode_write_strobes_tb_top.sv
// Self-checking bench for decoder and write strobes
// Assumes adws_pkg compiled first, consts header on the path
`timescale 1ns/100ps
module address_decode_write_strobes_tb_top;
   import adws_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        reset_n_i = 1'b0;
   adws_req_t   req_i = '0;
   logic [7:0]  chip_config_reg_0_i = 8'h00;
   logic [7:0]  config_byte_1_i = 8'h00;
   logic        external_access_select_n_i = 1'b1;
   logic        bus16_i = 1'b1;
   adws_sel_t   sel_o;
   logic        sel_valid_o, ext_cycle_o, boot_fetch_o;
   logic        low_byte_write_strobe_n_o, high_byte_write_strobe_n_o;
   logic [23:0] ext_addr_o, boot_addr_o;
   logic [15:0] lo_writes;
   int          fail_count = 0;
   int          n_compared = 0;
   int          exp_lo = 0;
   always #12.5 clk_sys_i = ~clk_sys_i;
   adws_decoder adws_decoder_i (.clk_sys_i, .reset_n_i, .req_i, .chip_config_reg_0_i,
      .config_byte_1_i, .external_access_select_n_i, .bus16_i, .sel_o, .sel_valid_o,
      .ext_cycle_o, .ext_addr_o, .boot_fetch_o, .boot_addr_o, .low_byte_write_strobe_n_o,
      .high_byte_write_strobe_n_o);
   adws_ext_mem adws_ext_mem_i (.clk_sys_i, .reset_n_i,
      .low_byte_write_strobe_n_i(low_byte_write_strobe_n_o), .lo_writes_o(lo_writes));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One request held for one edge, outputs then stand a cycle
   task automatic acc(input logic [23:0] a, input logic w, l, h, input adws_mode_t m);
      @(posedge clk_sys_i);
      #1 req_i = '{1'b1, w, a, l, h, m, 1'b0};
      @(posedge clk_sys_i);
      #1 req_i.valid = 1'b0;
   endtask
   task automatic print_verdict;
      $display("Compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic t_boot;
      for (int i = 0; i < 8 && boot_fetch_o !== 1'b1; i++) begin
         @(posedge clk_sys_i);
         #1;
      end
      chk(boot_fetch_o, 1'b1);
      chk(boot_addr_o, 24'hff2080);
   endtask
   task automatic t_map;
      logic [23:0]  a [19] = '{24'h000000, 24'h00001a, 24'h0003ff, 24'h000400, 24'h001bff,
         24'h001c00, 24'h001fe0, 24'h002000, 24'h002400, 24'h004000, 24'h1effff, 24'h1f0000,
         24'hff03ff, 24'hff0fff, 24'hff1000, 24'hff2080, 24'hff3fff, 24'hff4000, 24'hffffff};
      adws_target_t t [19] = '{ADWS_T_CPU_SFR, ADWS_T_LOW_RF, ADWS_T_UP_RF, ADWS_T_RAM,
         ADWS_T_EXT, ADWS_T_PSFR, ADWS_T_MSFR, ADWS_T_EXT, ADWS_T_ROM, ADWS_T_EXT, ADWS_T_EXT,
         ADWS_T_RESERVED, ADWS_T_ICE, ADWS_T_RAM, ADWS_T_EXT, ADWS_T_ROM, ADWS_T_ROM,
         ADWS_T_EXT, ADWS_T_EXT};
      for (int i = 0; i < 19; i++) begin
         acc(a[i], 1'b0, 1'b1, 1'b1, ADWS_M_OTHER);
         chk(sel_o.target, t[i]);
         chk(ext_cycle_o, t[i] == ADWS_T_EXT);
         chk(ext_addr_o, a[i]);
      end
      external_access_select_n_i = 1'b0;
      acc(24'hff2080, 1'b0, 1'b1, 1'b1, ADWS_M_OTHER);
      chk(sel_o.target, ADWS_T_EXT);
      external_access_select_n_i = 1'b1;
      config_byte_1_i = 8'h04;
      acc(24'h003fff, 1'b0, 1'b1, 1'b1, ADWS_M_OTHER);
      chk(sel_o.target, ADWS_T_EXT);
      config_byte_1_i = 8'h00;
      acc(24'h002400, 1'b0, 1'b1, 1'b1, ADWS_M_OTHER);
      chk(sel_o.local_addr, 24'h000400);
      acc(24'hff2400, 1'b0, 1'b1, 1'b1, ADWS_M_OTHER);
      chk(sel_o.local_addr, 24'h000400);
      acc(24'hff0abc, 1'b0, 1'b1, 1'b1, ADWS_M_OTHER);
      chk(sel_o.local_addr, 24'h000abc);
      acc(24'h000abc, 1'b0, 1'b1, 1'b1, ADWS_M_OTHER);
      chk(sel_o.local_addr, 24'h000abc);
      acc(24'hff2000, 1'b0, 1'b1, 1'b1, ADWS_M_OTHER);
      chk(sel_o.vector_area, 1'b1);
      acc(24'hff20c0, 1'b0, 1'b1, 1'b1, ADWS_M_OTHER);
      chk(sel_o.pih_area, 1'b1);
   endtask
   task automatic t_mode;
      acc(24'h0000ff, 1'b0, 1'b1, 1'b1, ADWS_M_DIRECT);
      chk({sel_valid_o, sel_o.mode_fault}, 2'b10);
      acc(24'h000100, 1'b0, 1'b1, 1'b1, ADWS_M_DIRECT);
      chk({sel_valid_o, sel_o.mode_fault}, 2'b01);
      acc(24'h001c00, 1'b0, 1'b1, 1'b1, ADWS_M_WINDOWED);
      chk({sel_valid_o, sel_o.mode_fault}, 2'b10);
      acc(24'h000400, 1'b0, 1'b1, 1'b1, ADWS_M_WINDOWED);
      chk({sel_valid_o, sel_o.mode_fault}, 2'b01);
   endtask
   task automatic t_strobe;
      logic el, eh;
      for (int c = 0; c < 2; c++) for (int b = 0; b < 2; b++)
         for (int k = 1; k < 4; k++) for (int w = 0; w < 2; w++) begin
            chip_config_reg_0_i = c ? 8'h04 : 8'h00;
            bus16_i = b[0];
            acc(24'h004000, w[0], k[0], k[1], ADWS_M_OTHER);
            el = c ? !w : !(w && (!b || k[0]));
            eh = c ? !(b && k[1]) : !(w && (!b || k[1]));
            chk(low_byte_write_strobe_n_o, el);
            chk(high_byte_write_strobe_n_o, eh);
            exp_lo += !el;
         end
      acc(24'h000400, 1'b1, 1'b1, 1'b1, ADWS_M_OTHER);
      chk({low_byte_write_strobe_n_o, high_byte_write_strobe_n_o}, 2'b11);
      acc(24'h1f0000, 1'b1, 1'b1, 1'b1, ADWS_M_OTHER);
      chk({low_byte_write_strobe_n_o, high_byte_write_strobe_n_o}, 2'b11);
      chk(sel_o.target, ADWS_T_RESERVED);
      @(posedge clk_sys_i);
      #1 chk(lo_writes, exp_lo);
   endtask
   // Mid-run reset: outputs idle, boot pulse again, then a write
   task automatic t_rst;
      @(posedge clk_sys_i);
      #1 reset_n_i = 1'b0;
      @(posedge clk_sys_i);
      #1 chk({sel_valid_o, ext_cycle_o, boot_fetch_o, low_byte_write_strobe_n_o,
         high_byte_write_strobe_n_o}, 5'b00011);
      chk(lo_writes, 16'h0000);
      reset_n_i = 1'b1;
      t_boot();
      acc(24'h004000, 1'b1, 1'b1, 1'b1, ADWS_M_OTHER);
      chk({low_byte_write_strobe_n_o, high_byte_write_strobe_n_o}, 2'b00);
   endtask
   initial begin
      repeat (10) @(posedge clk_sys_i);
      #1 reset_n_i = 1'b1;
      t_boot();
      t_map();
      t_mode();
      t_strobe();
      t_rst();
      print_verdict();
   end
   // Whole run needs about 3.4 us (some 135 cycles of 25 ns); generous margin
   initial begin
      #50us;
      fail_count++;
      print_verdict();
   end
endmodule
